// File: hdl/intc_prio.sv
// interrupt priority registers, external input sensing and request selection
`timescale 1ns/10ps
`include "intc_prio_params.svh"
// Overview of operation
// [RULE1] twelve 16-bit priority registers, four 4-bit levels each, read and write
// [RULE2] field value zero is lowest level 0, all ones is highest level 15
// [RULE3] fields sit in bits 15-12, 11-8, 7-4 and 3-0
// [RULE4] registers a and b cover external requests 0-7; rest cover peripheral groups
// [RULE5] sources sharing one field all take that field's level
// [RULE6] priority registers clear on reset and hardware standby, keep in software standby
// [RULE7] control register initialised by reset and hardware standby only
// [RULE8] control bit 15 reads the live non-maskable pin level, read only
// [RULE9] control bits 14 to 9 read zero; software writes zero
// [RULE10] edge select zero detects non-maskable request on falling edge
// [RULE11] edge select one detects non-maskable request on rising edge
// [RULE12] sense bit 7 serves request 0 down to bit 0 for request 7
// [RULE13] sense zero means low level, one means falling edge
// [RULE14] each source has a fixed vector; table entry at four times the number
// [RULE15] within a shared field, position 1 ranks highest
// [RULE16] equal levels resolve by fixed default order then position
// [RULE17] forward only when level strictly exceeds processor mask level
// [RULE18] writes to pin level bit ignored; updates act from the next cycle
module intc_prio
  import intc_prio_pkg::*;
#(
  parameter int NUM_SRC = 64
) (
  input  wire logic                 sys_clk,
  input  wire logic                 srst,
  input  wire logic                 hw_standby,
  input  wire logic                 nmi_pin,
  input  wire logic [7:0]           ext_req_n,
  input  wire logic [NUM_SRC-1:0]   periph_req,
  input  wire logic [NUM_SRC*6-1:0] periph_group,
  input  wire logic [NUM_SRC*8-1:0] periph_vector,
  input  wire logic [3:0]           processor_mask_level,
  input  wire logic                 irq_ack,
  output logic                      cpu_irq,
  output logic                      cpu_nmi,
  output logic [3:0]                cpu_level,
  output logic [7:0]                cpu_vector,
  output logic [9:0]                cpu_vector_offset,
  output logic [7:0]                ext_req_pending,
  output logic                      irq,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);

  logic [15:0]         prio_r [`PRIO_REG_COUNT];
  logic [8:0]          ctrl_r;
  logic [`EVT_COUNT-1:0] evt_status_r;
  logic [`EVT_COUNT-1:0] evt_mask_r;

  logic                nmi_prev_r;
  logic [7:0]          ext_prev_r;
  logic [7:0]          ext_edge_r;
  logic                nmi_pend_r;

  logic                aw_held_r;
  logic                w_held_r;
  logic [7:0]          aw_addr_r;
  logic [31:0]         w_data_r;
  logic [3:0]          w_strb_r;

  wr_state_t           wr_state_r;

  logic                wr_fire;
  logic                wr_hit;
  logic [15:0]         wr_val;
  logic [15:0]         rd_val;
  logic                rd_hit;
  logic                clr_all;

  logic                nmi_edge;
  logic [7:0]          ext_active;

  logic [3:0]          field_lvl [`NUM_GROUPS];

  level_t              best_lvl;
  logic [7:0]          best_vec;
  logic                best_ok;

  // reset and hardware standby clear alike; software standby is not an input
  assign clr_all = srst | hw_standby;

  // write address and data are latched apart, so either may come first;
  // the commit waits for both and the response holds off new writes

  // ---------------- write channel ----------------
  assign s_axi_awready = !aw_held_r && (wr_state_r == WR_IDLE);
  assign s_axi_wready  = !w_held_r && (wr_state_r == WR_IDLE);
  assign wr_fire       = aw_held_r && w_held_r && (wr_state_r == WR_IDLE);
  // unaligned or unmapped writes are answered with an error and change nothing
  assign wr_hit        = (aw_addr_r[1:0] == 2'b00) && (aw_addr_r <= `IRQ_MASK_ADDR);
  assign wr_val        = w_data_r[15:0];
  // only the low half carries register bits; the upper half is ignored

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_state_r   <= WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_OKAY;
    end else begin
      case (wr_state_r)
        WR_IDLE: begin
          if (wr_fire) begin
            wr_state_r   <= WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `AXI_OKAY : `AXI_SLVERR;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_r   <= WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        // unused state codes fall back to idle
        default: begin
          wr_state_r   <= WR_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // [RULE1] priority register writes
  // [RULE6] cleared by reset and hardware standby
  // one register per generate step; byte strobes guard each half
  genvar gi;
  generate
    for (gi = 0; gi < `PRIO_REG_COUNT; gi++) begin : g_prio
      always_ff @(posedge sys_clk) begin
        if (clr_all) begin
          prio_r[gi] <= `PRIO_RESET;
        end else if (wr_fire && aw_addr_r == 8'(`PRIO_BASE_ADDR + 4 * gi)) begin
          if (w_strb_r[0]) prio_r[gi][7:0]  <= wr_val[7:0];
          if (w_strb_r[1]) prio_r[gi][15:8] <= wr_val[15:8];
        end
      end
    end
  endgenerate

  // [RULE7] control register
  // only bits 8 down to 0 are stored; bit 15 and the zero bits are built at read time
  // [RULE18] pin level bit and zero bits are not storage
  always_ff @(posedge sys_clk) begin
    if (clr_all) begin
      ctrl_r <= 9'(`SENSE_CTRL_RESET);
    end else if (wr_fire && aw_addr_r == `SENSE_CTRL_ADDR) begin
      if (w_strb_r[0]) ctrl_r[7:0] <= wr_val[7:0];
      if (w_strb_r[1]) ctrl_r[8]   <= wr_val[8];
    end
  end

  // ---------------- read channel ----------------
  always_comb begin
    rd_val = 16'h0000;
    rd_hit = 1'b1;

    if (s_axi_araddr < 8'(4 * `PRIO_REG_COUNT) && s_axi_araddr[1:0] == 2'b00) begin
      rd_val = prio_r[s_axi_araddr[5:2]];
    end else if (s_axi_araddr == `SENSE_CTRL_ADDR) begin
      // [RULE8] live pin level; [RULE9] bits 14-9 zero
      rd_val = {nmi_pin, 6'b000000, ctrl_r};
    end else if (s_axi_araddr == `IRQ_STATUS_ADDR) begin
      rd_val = 16'(evt_status_r);
    end else if (s_axi_araddr == `IRQ_MASK_ADDR) begin
      rd_val = 16'(evt_mask_r);
    end else begin
      rd_hit = 1'b0;
    end
  end

  // one read at a time: the address is refused while data waits
  assign s_axi_arready = !s_axi_rvalid;


  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {16'h0000, rd_val};
      s_axi_rresp  <= rd_hit ? `AXI_OKAY : `AXI_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- input sensing ----------------
  // previous samples start at the idle high level so reset makes no false edge
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      nmi_prev_r <= 1'b1;
      ext_prev_r <= 8'hFF;
    end else begin
      nmi_prev_r <= nmi_pin;
      ext_prev_r <= ext_req_n;
    end
  end

  // [RULE10] falling edge when select is zero
  // [RULE11] rising edge when select is one
  assign nmi_edge = ctrl_r[`CTRL_EDGE_SEL_BIT] ? (nmi_pin && !nmi_prev_r)
                                               : (!nmi_pin && nmi_prev_r);

  // held until the core takes it; a new edge wins over the acknowledge
  // the pin is taken as already synchronous; no extra flops sit in front
  always_ff @(posedge sys_clk) begin
    if (clr_all) begin
      nmi_pend_r <= 1'b0;
    end else if (nmi_edge) begin
      nmi_pend_r <= 1'b1;
    end else if (irq_ack && cpu_nmi) begin
      nmi_pend_r <= 1'b0;
    end
  end

  // [RULE12] bit 7 serves request 0 down to bit 0 for request 7
  // level mode reads the pin directly, so a released pin drops the request at once
  // [RULE13] zero is low level, one is falling edge held
  generate
    for (gi = 0; gi < `NUM_EXT_REQ; gi++) begin : g_ext
      always_ff @(posedge sys_clk) begin
        if (clr_all) begin
          ext_edge_r[gi] <= 1'b0;
        end else if (ctrl_r[7 - gi] && ext_prev_r[gi] && !ext_req_n[gi]) begin
          ext_edge_r[gi] <= 1'b1;
        end else if (irq_ack && cpu_irq && cpu_vector == 8'(64 + gi)) begin
          ext_edge_r[gi] <= 1'b0;
        end
      end
      assign ext_active[gi] = ctrl_r[7 - gi] ? ext_edge_r[gi] : !ext_req_n[gi];
    end
  endgenerate
  assign ext_req_pending = ext_active;
  // edge requests stay pending while masked out; only acknowledge, reset or hardware standby drops them

  // ---------------- arbitration ----------------
  // [RULE3] field order 15-12, 11-8, 7-4, 3-0
  // [RULE4] group g is register g/4, field g%4; groups 0-7 are requests 0-7
  // groups 48 and up have no field and read as level 0
  generate
    for (gi = 0; gi < `NUM_GROUPS; gi++) begin : g_fld
      assign field_lvl[gi] = prio_r[gi / 4][15 - 4 * (gi % 4) -: 4];
    end
  endgenerate

  // [RULE2] level compare 0 lowest to 15 highest
  // [RULE16] scan order is default priority; strict compare keeps the earlier
  // a linear scan keeps the tie rule obvious at the cost of a long compare chain
  always_comb begin
    level_t lvl;
    logic [5:0] grp;
    best_lvl = 4'h0;
    best_vec = 8'h00;
    best_ok  = 1'b0;
    lvl      = 4'h0;
    grp      = 6'h00;

    // external requests first: on a tie they outrank every peripheral
    for (int i = 0; i < `NUM_EXT_REQ; i++) begin
      lvl = field_lvl[i];
      if (ext_active[i] && (!best_ok || lvl > best_lvl)) begin
        best_ok  = 1'b1;
        best_lvl = lvl;
        best_vec = 8'(64 + i);
      end
    end
    // [RULE5] each member of a group takes its field's level
    // [RULE15] sources listed by position within their field, position 1 first
    for (int i = 0; i < NUM_SRC; i++) begin
      grp = periph_group[i*6 +: 6];
      lvl = (grp < 6'(`NUM_GROUPS)) ? field_lvl[grp] : 4'h0;
      if (periph_req[i] && (!best_ok || lvl > best_lvl)) begin
        best_ok  = 1'b1;
        best_lvl = lvl;
        best_vec = periph_vector[i*8 +: 8];
      end
    end
  end

  // [RULE17] strictly above the processor mask level
  // [RULE14] vector table entry offset is four times the vector
  // the non-maskable request bypasses the mask and holds until acknowledged
  always_ff @(posedge sys_clk) begin
    if (clr_all) begin
      cpu_irq           <= 1'b0;
      cpu_nmi           <= 1'b0;
      cpu_level         <= 4'h0;
      cpu_vector        <= 8'h00;
      cpu_vector_offset <= 10'h000;
    end else if (nmi_pend_r && !(irq_ack && cpu_nmi)) begin
      cpu_irq           <= 1'b1;
      cpu_nmi           <= 1'b1;
      cpu_level         <= 4'hF;
      cpu_vector        <= `NMI_VECTOR;
      cpu_vector_offset <= 10'(`NMI_VECTOR * `VECTOR_BYTES);
    end else begin
      cpu_irq           <= best_ok && (best_lvl > processor_mask_level);
      cpu_nmi           <= 1'b0;
      cpu_level         <= best_lvl;
      cpu_vector        <= best_vec;
      cpu_vector_offset <= 10'(best_vec * `VECTOR_BYTES);
    end
  end

  // ---------------- event status ----------------
  // set wins over a write-one clear in the same cycle
  // the mask only gates the irq output; the status bits always record events
  always_ff @(posedge sys_clk) begin
    if (clr_all) begin
      evt_status_r <= '0;
      evt_mask_r   <= '0;
    end else begin
      for (int b = 0; b < `EVT_COUNT; b++) begin
        if ((b == `EVT_NMI_BIT && nmi_edge) || (b == `EVT_TAKEN_BIT && irq_ack && cpu_irq)) begin
          evt_status_r[b] <= 1'b1;
        end else if (wr_fire && aw_addr_r == `IRQ_STATUS_ADDR && w_strb_r[0] && wr_val[b]) begin
          evt_status_r[b] <= 1'b0;
        end
      end
      if (wr_fire && aw_addr_r == `IRQ_MASK_ADDR && w_strb_r[0]) begin
        evt_mask_r <= wr_val[`EVT_COUNT-1:0];
      end
    end
  end

  assign irq = |(evt_status_r & evt_mask_r);

endmodule : intc_prio

// File: hdl/intc_prio_params.svh
// offsets, field positions, reset values and source codes of the priority controller
`ifndef INTC_PRIO_PARAMS_SVH
`define INTC_PRIO_PARAMS_SVH
`define PRIO_REG_COUNT        12
`define PRIO_BASE_ADDR        8'h00
`define SENSE_CTRL_ADDR       8'h30
`define IRQ_STATUS_ADDR       8'h34
`define IRQ_MASK_ADDR         8'h38
`define PRIO_RESET            16'h0000
`define SENSE_CTRL_RESET      16'h0000
`define CTRL_PIN_LEVEL_BIT    15
`define CTRL_EDGE_SEL_BIT     8
`define CTRL_WRITABLE_MASK    16'h01FF
`define FIELD_WIDTH           4
`define FIELDS_PER_REG        4
`define NUM_EXT_REQ           8
`define NUM_GROUPS            48
`define VECTOR_BYTES          4
`define NMI_VECTOR            8'h0B
`define EVT_NMI_BIT           0
`define EVT_TAKEN_BIT         1
`define EVT_COUNT             2
`define AXI_OKAY              2'b00
`define AXI_SLVERR            2'b10
`endif

// File: hdl/intc_prio_pkg.sv
// types shared by the priority controller
package intc_prio_pkg;
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } wr_state_t;
  typedef logic [3:0] level_t;
endpackage : intc_prio_pkg

// File: testbench/intc_prio_asserts.sv
// port checker for the interrupt priority controller
`timescale 1ns/10ps
`include "intc_prio_params.svh"
module intc_prio_asserts (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        nmi_pin,
  input wire logic [3:0]  processor_mask_level,
  input wire logic        cpu_irq,
  input wire logic        cpu_nmi,
  input wire logic [3:0]  cpu_level,
  input wire logic [7:0]  cpu_vector,
  input wire logic [9:0]  cpu_vector_offset,
  input wire logic        irq,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  mask_strict_a: assert property (
    cpu_irq && !cpu_nmi |-> cpu_level > $past(processor_mask_level)) else $error("level vs mask");
  vec_offset_a: assert property (
    cpu_irq |-> cpu_vector_offset == {cpu_vector, 2'h0}) else $error("vector offset");
  nmi_top_a: assert property (
    cpu_nmi |-> cpu_level == 4'hF && cpu_vector == `NMI_VECTOR) else $error("nmi level");
  // the pin edge needs two samples, so look back up to four
  nmi_cause_a: assert property (
    $rose(cpu_nmi) |-> $past(nmi_pin, 1) != $past(nmi_pin, 2) || $past(nmi_pin, 2)
    != $past(nmi_pin, 3) || $past(nmi_pin, 3) != $past(nmi_pin, 4)) else $error("nmi cause");
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  b_refuse_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready in response");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata");
  r_refuse_a: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("arready in response");
  r_err_a: assert property (
    s_axi_rvalid && s_axi_rresp == `AXI_SLVERR |-> s_axi_rdata == 32'h0) else $error("err data");
  rst_idle_a: assert property (
    $fell(srst) |-> !cpu_irq && !irq && !s_axi_bvalid && !s_axi_rvalid) else $error("reset");
endmodule : intc_prio_asserts

bind intc_prio intc_prio_asserts intc_prio_asserts_inst (.*);

// File: testbench/periph_src_model.sv
// two peripheral request sources sharing one priority field
`timescale 1ns/10ps
module periph_src_model (
  input  wire logic [1:0]  src_on,
  output logic      [1:0]  periph_req,
  output logic      [11:0] periph_group,
  output logic      [15:0] periph_vector
);
  // both in field j 11-8, source 0 at position 1
  assign periph_group = {6'h25, 6'h25};
  // fixed vectors of timer match and converter
  assign periph_vector = {8'hBD, 8'hBC};
  assign periph_req = src_on;
endmodule : periph_src_model

// File: testbench/tb.sv
// self-checking bench for the interrupt priority controller
`timescale 1ns/10ps
`include "intc_prio_params.svh"
module tb;
  logic        sys_clk, srst, hw_standby, nmi_pin, irq_ack, cpu_irq, cpu_nmi, irq;
  logic [1:0]  src_on, periph_req, s_axi_bresp, s_axi_rresp, last_b;
  logic [3:0]  processor_mask_level, cpu_level, s_axi_wstrb;
  logic [7:0]  ext_req_n, cpu_vector, ext_req_pending, s_axi_awaddr, s_axi_araddr;
  logic [9:0]  cpu_vector_offset;
  logic [11:0] periph_group;
  logic [15:0] periph_vector;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          fails, checked, i;
  intc_prio #(.NUM_SRC(2)) intc_prio_inst (.*);
  periph_src_model periph_src_model_inst (.*);
  always #5 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic tmo();
    fails++;
    $display("CHECK FAILED at %0t: no answer", $time);
    print_verdict();
  endtask : tmo
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    int   n;
    logic ad, wd;
    ad = 1'h0;
    wd = 1'h0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (ad && wd && s_axi_bvalid) break;
      ad = ad | s_axi_awready;
      wd = wd | s_axi_wready;
      if (ad) s_axi_awvalid <= 1'h0;
      if (wd) s_axi_wvalid <= 1'h0;
    end
    if (n == 50) tmo();
    last_b = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (s_axi_rvalid) break;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    if (n == 50) tmo();
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, r);
    s_axi_rready <= 1'h0;
  endtask : rc
  // the note fixes at most two edges of latency; four leaves slack
  task automatic cx(input logic e, input logic nm, input logic [3:0] l, input logic [7:0] v);
    repeat (4) @(posedge sys_clk);
    if (e) chk({cpu_irq, cpu_nmi, cpu_level, cpu_vector, cpu_vector_offset}, {e, nm, l, v, v, 2'h0});
    else chk(cpu_irq, 1'h0);
  endtask : cx
  task automatic ack();
    irq_ack <= 1'h1;
    @(posedge sys_clk);
    irq_ack <= 1'h0;
  endtask : ack
  task automatic t_reset();
    for (i = 0; i < 12; i++) rc(8'(i * 4), 32'h0, `AXI_OKAY);
    rc(8'h30, 32'h8000, `AXI_OKAY);
    rc(8'h3C, 32'h0, `AXI_SLVERR);
    rc(8'h01, 32'h0, `AXI_SLVERR);
  endtask : t_reset
  task automatic t_regs();
    for (i = 0; i < 12; i++) wr(8'(i * 4), {i[3:0], 8'hA5, ~i[3:0]});
    for (i = 0; i < 12; i++) rc(8'(i * 4), {16'h0, i[3:0], 8'hA5, ~i[3:0]}, `AXI_OKAY);
    wr(8'h3C, 16'hFFFF);
    chk(last_b, `AXI_SLVERR);
    wr(8'h30, 16'hFFFF);
    rc(8'h30, 32'h81FF, `AXI_OKAY);
    hw_standby <= 1'h1;
    @(posedge sys_clk);
    hw_standby <= 1'h0;
    rc(8'h2C, 32'h0, `AXI_OKAY);
    rc(8'h30, 32'h8000, `AXI_OKAY);
  endtask : t_regs
  task automatic t_nmi();
    wr(8'h38, 16'h0001);
    nmi_pin <= 1'h0;
    cx(1'h1, 1'h1, 4'hF, `NMI_VECTOR);
    rc(8'h30, 32'h0, `AXI_OKAY);
    rc(8'h34, 32'h1, `AXI_OKAY);
    chk(irq, 1'h1);
    wr(8'h34, 16'h0001);
    chk(irq, 1'h0);
    ack();
    nmi_pin <= 1'h1;
    cx(1'h0, 1'h0, 4'h0, 8'h00);
    wr(8'h30, 16'h0100);
    nmi_pin <= 1'h0;
    cx(1'h0, 1'h0, 4'h0, 8'h00);
    nmi_pin <= 1'h1;
    cx(1'h1, 1'h1, 4'hF, `NMI_VECTOR);
    wr(8'h38, 16'h0000);
    chk(irq, 1'h0);
    ack();
  endtask : t_nmi
  task automatic t_ext();
    wr(8'h00, 16'h5000);
    processor_mask_level <= 4'h2;
    ext_req_n <= 8'hFE;
    cx(1'h1, 1'h0, 4'h5, 8'h40);
    chk(ext_req_pending, 8'h01);
    processor_mask_level <= 4'h5;
    cx(1'h0, 1'h0, 4'h0, 8'h00);
    processor_mask_level <= 4'h4;
    cx(1'h1, 1'h0, 4'h5, 8'h40);
    ext_req_n <= 8'hFF;
    cx(1'h0, 1'h0, 4'h0, 8'h00);
    wr(8'h04, 16'h000F);
    wr(8'h30, 16'h0001);
    ext_req_n <= 8'h7F;
    cx(1'h1, 1'h0, 4'hF, 8'h47);
    ext_req_n <= 8'hFF;
    cx(1'h1, 1'h0, 4'hF, 8'h47);
    ack();
    processor_mask_level <= 4'h0;
    ext_req_n <= 8'hBF;
    cx(1'h0, 1'h0, 4'h0, 8'h00);
    ext_req_n <= 8'hFF;
  endtask : t_ext
  task automatic t_periph();
    wr(8'h24, 16'h0900);
    processor_mask_level <= 4'h4;
    src_on <= 2'h3;
    ext_req_n <= 8'hFE;
    cx(1'h1, 1'h0, 4'h9, 8'hBC);
    src_on <= 2'h2;
    cx(1'h1, 1'h0, 4'h9, 8'hBD);
    src_on <= 2'h0;
    cx(1'h1, 1'h0, 4'h5, 8'h40);
    ext_req_n <= 8'hFF;
    cx(1'h0, 1'h0, 4'h0, 8'h00);
  endtask : t_periph
  initial begin
    {sys_clk, hw_standby, irq_ack, src_on, processor_mask_level} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {srst, nmi_pin, ext_req_n, s_axi_wstrb} = {2'h3, 8'hFF, 4'h3};
    repeat (16) @(posedge sys_clk);
    srst <= 1'h0;
    t_reset();
    t_regs();
    t_nmi();
    t_ext();
    t_periph();
    print_verdict();
  end
endmodule : tb
